// >>> core/xto_clock_reset_power_control.sv
// Purpose: crystal clock output, reset output, digital timing and power modes
// Assumes: hclk is the crystal clock sampled at twice its rate
// Notes: ahb-lite slave, zero wait states
// How it works
// - osc_ready releases reset, gates clock when enabled
// - mcu clock is crystal divided by three
// - clock enable unsynchronised, first cycle may truncate
// - mcu clock high and low phases equal
// - base digital clock is crystal over sixteen
// - base clock times bit check and tx rate
// - bit period is base times range times limit
// - frequency word is sum of two parts
// - carrier uses word plus band integer part
// - reset output low while supply out bad
// - power-on input wakes device from off
// - any of five buttons wakes from off
// - clearing supply enable switches supply output off
// - four monitor flags reported to software
// - aux low, no wake: stay off, refuse bus
// - idle and sleep trim oscillator load caps
// - wake from off pulses interrupt and sets cause bit
// - low battery clears only when recovered and read, or recovered with reset output low
// - supply drop resets logic only when enabled
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "xto_ctrl_defines.svh"
module xto_clock_reset_power_control
(
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog monitors
  input wire logic osc_amp_ok,
  input wire logic digital_supply_good,
  input wire logic supply_out_good,
  input wire logic low_batt_in,
  input wire logic aux_supply_in,
  // wake inputs
  input wire logic power_on_in,
  input wire logic [4:0] button_n,
  // outputs to microcontroller and analog
  output logic mcu_clk,
  output logic mcu_reset_n,
  output logic irq,
  output logic supply_out,
  output logic internal_supply_en,
  output logic load_cap_reduce,
  // digital timing
  output logic base_tick,
  output logic bitrate_tick,
  output logic [12:0] synth_word_a,
  output logic band_select_bit
);
  // ======================================================
  // state
  xto_ctrl_pkg::pmode_e mode_r, mode_nxt;
  logic [7:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, ctrl3_r, ctrl3_nxt;
  logic [7:0] ctrl4_r, ctrl4_nxt, ctrl6_r, ctrl6_nxt;
  logic [4:0] wake_btn_r, wake_btn_nxt;
  logic wake_pwr_r, wake_pwr_nxt, low_batt_r, low_batt_nxt, irq_r, irq_nxt;
  logic osc_ready_r, osc_ready_nxt, wr_pend_r, wr_pend_nxt, rst_n_r, rst_n_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt, xcnt_r, xcnt_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [2:0] cnt6_r, cnt6_nxt;
  logic [4:0] cnt32_r, cnt32_nxt;
  logic [12:0] word_r, word_nxt;
  logic mclk_r, mclk_nxt, base_r, base_nxt, brt_r, brt_nxt;
  logic sup_r, sup_nxt, isup_r, isup_nxt, lcap_r, lcap_nxt;
  // ======================================================
  // helpers
  logic acc, rd_acc, status_rd, wake_any, logic_rst;
  logic [7:0] status_v, period_v;

  function automatic logic [7:0] bit_period(input logic [1:0] range, input logic rate_limit_factor);
    logic [7:0] base;
    base = 8'(`RANGE0_MULT) >> range;
    bit_period = rate_limit_factor ? {base[6:0], 1'b0} : base;
  endfunction : bit_period

  assign acc = hsel && hready && htrans[1] && (hsize == 3'h2) && (mode_r != xto_ctrl_pkg::PM_OFF);
  assign rd_acc = acc && !hwrite;
  assign status_rd = rd_acc && (haddr == `ADDR_STATUS);
  assign wake_any = power_on_in || (button_n != 5'h1f);
  assign logic_rst = !supply_out_good && ctrl3_r[`CTRL3_SUPPLY_EN_BIT];
  assign status_v = {wake_pwr_r, low_batt_r, supply_out_good, digital_supply_good,
    osc_ready_r, mode_r == xto_ctrl_pkg::PM_AUX, mode_r};
  assign period_v = bit_period(ctrl6_r[1:0], ctrl4_r[0]);

  // ======================================================
  // power mode sequencer
  always_comb
  begin
    mode_nxt = mode_r;
    irq_nxt = 1'b0;
    case (mode_r)
      xto_ctrl_pkg::PM_OFF:
      begin
        if (wake_any)
        begin
          mode_nxt = xto_ctrl_pkg::PM_IDLE;
          irq_nxt = 1'b1;
        end
        else if (aux_supply_in)
        begin
          mode_nxt = xto_ctrl_pkg::PM_AUX;
          irq_nxt = 1'b1;
        end
      end
      xto_ctrl_pkg::PM_AUX:
      begin
        if (wake_any)
          mode_nxt = xto_ctrl_pkg::PM_IDLE;
        else if (!aux_supply_in)
          mode_nxt = xto_ctrl_pkg::PM_OFF;
      end
      xto_ctrl_pkg::PM_IDLE, xto_ctrl_pkg::PM_SLEEP:
      begin
        mode_nxt = ctrl1_r[`CTRL1_SLEEP_BIT] ? xto_ctrl_pkg::PM_SLEEP : xto_ctrl_pkg::PM_IDLE;
        // off only with every wake source released
        if (wr_pend_r && wr_addr_r == `ADDR_OFF_CMD && !wake_any && !aux_supply_in)
          mode_nxt = xto_ctrl_pkg::PM_OFF;
      end
      default:
        mode_nxt = xto_ctrl_pkg::PM_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= xto_ctrl_pkg::PM_OFF;
      irq_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ======================================================
  // bus slave and control registers
  always_comb
  begin
    wr_pend_nxt = acc && hwrite;
    wr_addr_nxt = haddr;
    hrdata_nxt = hrdata_r;
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    ctrl3_nxt = ctrl3_r;
    ctrl4_nxt = ctrl4_r;
    ctrl6_nxt = ctrl6_r;
    if (rd_acc)
    begin
      case (haddr)
        `ADDR_CTRL1: hrdata_nxt = {24'h000000, ctrl1_r};
        `ADDR_CTRL2: hrdata_nxt = {24'h000000, ctrl2_r};
        `ADDR_CTRL3: hrdata_nxt = {24'h000000, ctrl3_r};
        `ADDR_CTRL4: hrdata_nxt = {24'h000000, ctrl4_r};
        `ADDR_CTRL6: hrdata_nxt = {24'h000000, ctrl6_r};
        `ADDR_STATUS: hrdata_nxt = {19'h00000, wake_btn_r, status_v};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
    else if (acc)
      hrdata_nxt = 32'h00000000;
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        `ADDR_CTRL1: ctrl1_nxt = hwdata[7:0];
        `ADDR_CTRL2: ctrl2_nxt = hwdata[7:0];
        `ADDR_CTRL3: ctrl3_nxt = hwdata[7:0];
        `ADDR_CTRL4: ctrl4_nxt = hwdata[7:0];
        `ADDR_CTRL6: ctrl6_nxt = hwdata[7:0];
        default: ctrl1_nxt = ctrl1_r;
      endcase
    end
    // supply loss with supply enabled, or off mode, returns control to defaults
    if (logic_rst || mode_r == xto_ctrl_pkg::PM_OFF)
    begin
      wr_pend_nxt = 1'b0;
      ctrl1_nxt = `CTRL1_RST;
      ctrl2_nxt = `CTRL2_RST;
      ctrl3_nxt = `CTRL3_RST;
      ctrl4_nxt = `CTRL4_RST;
      ctrl6_nxt = `CTRL6_RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      ctrl1_r <= `CTRL1_RST;
      ctrl2_r <= `CTRL2_RST;
      ctrl3_r <= `CTRL3_RST;
      ctrl4_r <= `CTRL4_RST;
      ctrl6_r <= `CTRL6_RST;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      ctrl3_r <= ctrl3_nxt;
      ctrl4_r <= ctrl4_nxt;
      ctrl6_r <= ctrl6_nxt;
    end
  end

  // ======================================================
  // status flags, set beats clear
  always_comb
  begin
    wake_pwr_nxt = wake_pwr_r && !status_rd;
    wake_btn_nxt = status_rd ? 5'h00 : wake_btn_r;
    if (mode_r == xto_ctrl_pkg::PM_OFF && power_on_in)
      wake_pwr_nxt = 1'b1;
    if (mode_r == xto_ctrl_pkg::PM_OFF)
      wake_btn_nxt = wake_btn_nxt | ~button_n;
    // clear only after recovery, on status read or reset output low
    low_batt_nxt = low_batt_r && !(!low_batt_in && (status_rd || !rst_n_r));
    if (low_batt_in)
      low_batt_nxt = 1'b1;
    osc_ready_nxt = osc_amp_ok && mode_r != xto_ctrl_pkg::PM_OFF;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_pwr_r <= 1'b0;
      wake_btn_r <= 5'h00;
      low_batt_r <= 1'b0;
      osc_ready_r <= 1'b0;
    end
    else
    begin
      wake_pwr_r <= wake_pwr_nxt;
      wake_btn_r <= wake_btn_nxt;
      low_batt_r <= low_batt_nxt;
      osc_ready_r <= osc_ready_nxt;
    end
  end

  // ======================================================
  // clock dividers and reset output
  always_comb
  begin
    cnt6_nxt = (cnt6_r == 3'(`MCU_CLK_HCLK - 1)) ? 3'h0 : cnt6_r + 3'h1;
    // divider free runs; gating it mid-cycle may cut the first pulse
    mclk_nxt = osc_ready_r && supply_out_good && ctrl3_r[`CTRL3_CLK_ON_BIT]
      && (cnt6_nxt < 3'(`MCU_CLK_HALF));
    rst_n_nxt = osc_ready_r && supply_out_good;
    cnt32_nxt = cnt32_r + 5'h01;
    base_nxt = (cnt32_r == 5'(`BASE_CLK_HCLK - 1));
    xcnt_nxt = xcnt_r;
    brt_nxt = 1'b0;
    if (base_r)
      if (xcnt_r >= period_v - 8'h01)
      begin
        xcnt_nxt = 8'h00;
        brt_nxt = 1'b1;
      end
      else
        xcnt_nxt = xcnt_r + 8'h01;
    // low part fr6..fr0, high part synth_word_a_bit_msb..fr7 weighted by 128
    word_nxt = 13'({6'h00, ctrl2_r[7:1]}) + {ctrl3_r[7:2], 7'h00};
    sup_nxt = mode_r != xto_ctrl_pkg::PM_OFF && ctrl3_r[`CTRL3_SUPPLY_EN_BIT];
    isup_nxt = mode_r != xto_ctrl_pkg::PM_OFF;
    lcap_nxt = mode_r == xto_ctrl_pkg::PM_IDLE || mode_r == xto_ctrl_pkg::PM_SLEEP;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt6_r <= 3'h0;
      mclk_r <= 1'b0;
      rst_n_r <= 1'b0;
      cnt32_r <= 5'h00;
      base_r <= 1'b0;
      xcnt_r <= 8'h00;
      brt_r <= 1'b0;
      word_r <= 13'h0000;
      sup_r <= 1'b0;
      isup_r <= 1'b0;
      lcap_r <= 1'b0;
    end
    else
    begin
      cnt6_r <= cnt6_nxt;
      mclk_r <= mclk_nxt;
      rst_n_r <= rst_n_nxt;
      cnt32_r <= cnt32_nxt;
      base_r <= base_nxt;
      xcnt_r <= xcnt_nxt;
      brt_r <= brt_nxt;
      word_r <= word_nxt;
      sup_r <= sup_nxt;
      isup_r <= isup_nxt;
      lcap_r <= lcap_nxt;
    end
  end

  // ======================================================
  // outputs
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mcu_clk = mclk_r;
  assign mcu_reset_n = rst_n_r;
  assign irq = irq_r;
  assign supply_out = sup_r;
  assign internal_supply_en = isup_r;
  assign load_cap_reduce = lcap_r;
  assign base_tick = base_r;
  assign bitrate_tick = brt_r;
  assign synth_word_a = word_r;
  assign band_select_bit = ctrl1_r[`CTRL1_BAND_BIT];
endmodule : xto_clock_reset_power_control

// >>> core/xto_ctrl_defines.svh
// Purpose: offsets, field positions, reset values and divider counts
// Assumes: hclk runs at twice the crystal rate
// Notes: definitions only
`ifndef XTO_CTRL_DEFINES_SVH
`define XTO_CTRL_DEFINES_SVH
// ======================================================
// register byte offsets
`define ADDR_CTRL1 8'h00
`define ADDR_CTRL2 8'h04
`define ADDR_CTRL3 8'h08
`define ADDR_CTRL4 8'h0c
`define ADDR_CTRL6 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_OFF_CMD 8'h18
// ======================================================
// field positions
`define CTRL1_BAND_BIT 4
`define CTRL1_SLEEP_BIT 1
`define CTRL3_SUPPLY_EN_BIT 1
`define CTRL3_CLK_ON_BIT 0
// ======================================================
// reset values
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define CTRL3_RST 8'h03
`define CTRL4_RST 8'h00
`define CTRL6_RST 8'h00
// ======================================================
// divider counts in crystal, hclk and base clock cycles
`define HCLK_PER_XTO 2
`define MCU_CLK_DIV 3
`define BASE_CLK_DIV 16
`define MCU_CLK_HCLK (`MCU_CLK_DIV * `HCLK_PER_XTO)
`define MCU_CLK_HALF (`MCU_CLK_HCLK / 2)
`define BASE_CLK_HCLK (`BASE_CLK_DIV * `HCLK_PER_XTO)
`define RANGE0_MULT 8
`endif

// >>> core/xto_ctrl_pkg.sv
// Purpose: types shared by the clock, reset and power control
// Assumes: nothing
// Notes: constants live in the defines header
package xto_ctrl_pkg;
  // ======================================================
  // power modes, gray coded along off-idle-sleep
  typedef enum logic [1:0]
  {
    PM_OFF = 2'b00,
    PM_IDLE = 2'b01,
    PM_SLEEP = 2'b11,
    PM_AUX = 2'b10
  } pmode_e;
  typedef logic [12:0] synth_word_a_word_t;
endpackage : xto_ctrl_pkg

// >>> dv/mcu_model.sv
// Purpose: host fed by the device clock and reset
// Assumes: wake requests come from the bench
// Notes: counts clock rises out of reset
`timescale 1ns/10ps
module mcu_model
(
  // device side
  input wire logic hclk,
  input wire logic mcu_clk,
  input wire logic mcu_reset_n,
  input wire logic wake_req,
  // host side
  output logic power_on_in,
  output int rises,
  output logic [12:0] synth_word_a_word
);
  // ======================================================
  // host behaviour
  initial rises = 0;
  initial power_on_in = 1'b0;
  // keeps clock harmonics off the receive band
  assign synth_word_a_word = 13'h0f3c;
  // a short first pulse is still a clock
  always @(posedge mcu_clk)
    if (mcu_reset_n === 1'b1)
      rises <= rises + 1;
  // follows wake_req one hclk later, so a long press wastes pull-up current
  always @(posedge hclk)
    power_on_in <= wake_req;
endmodule : mcu_model

// >>> dv/testbench.sv
// Purpose: bus-driven scenarios for the clock control block
// Assumes: zero wait states, hready tied to hreadyout
// Notes: no random stimulus
`timescale 1ns/10ps
`include "xto_ctrl_defines.svh"
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake_req = 1'b0;
  logic osc_amp_ok = 1'b0, digital_supply_good = 1'b1, supply_out_good = 1'b1;
  logic low_batt_in = 1'b0, aux_supply_in = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [4:0] button_n = 5'h1f;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, mcu_clk, mcu_reset_n, irq, supply_out, internal_supply_en;
  logic load_cap_reduce, base_tick, bitrate_tick, band_select_bit, power_on_in;
  logic [12:0] synth_word_a, synth_word_a_word;
  logic [12:0] words [3];
  int rises, r0, c, i, failures = 0, samples_checked = 0;
  always #50 hclk = ~hclk;
  xto_clock_reset_power_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc_amp_ok, .digital_supply_good,
    .supply_out_good, .low_batt_in, .aux_supply_in, .power_on_in, .button_n, .mcu_clk,
    .mcu_reset_n, .irq, .supply_out, .internal_supply_en, .load_cap_reduce, .base_tick,
    .bitrate_tick, .synth_word_a, .band_select_bit);
  mcu_model host (.hclk, .mcu_clk, .mcu_reset_n, .wake_req, .power_on_in, .rises, .synth_word_a_word);
  // ======================================================
  // tasks
  task print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : step
  task rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : xfer
  task wait_irq();
    int n;
    n = 0;
    #1;
    while (irq !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    chk("irq", irq, 1'b1);
  endtask : wait_irq
  task period(output int c);
    c = 0;
    do
    begin
      step(1);
      c++;
    end
    while (bitrate_tick !== 1'b1 && c < 1100);
    if (c >= 1100)
    begin
      failures++;
      print_verdict();
    end
  endtask : period
  // ======================================================
  // scenarios
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, `ADDR_CTRL4, 32'h1);
    xfer(1'b0, `ADDR_CTRL3, 32'h0);
    chk("refused read", q, 32'h0);
    step(2);
    chk("off outputs", {internal_supply_en, supply_out, load_cap_reduce}, 3'h0);
    for (i = 0; i < 5; i++)
    begin
      @(posedge hclk);
      button_n <= ~(5'h01 << i);
      @(posedge hclk);
      button_n <= 5'h1f;
      wait_irq();
      xfer(1'b0, `ADDR_STATUS, 32'h0);
      chk("button cause", q[12:8], 5'h01 << i);
      xfer(1'b1, `ADDR_OFF_CMD, 32'h0);
      step(3);
      chk("back off", internal_supply_en, 1'b0);
    end
    $display("test buttons done");
    @(posedge hclk);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    wait_irq();
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("power cause", {q[7], q[5:4], q[1:0]}, 5'h1d);
    chk("load caps", load_cap_reduce, 1'b1);
    xfer(1'b0, `ADDR_CTRL4, 32'h0);
    chk("refused write", q, 32'h0);
    xfer(1'b1, `ADDR_CTRL1, 32'h2);
    step(2);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("sleep mode", {q[1:0], load_cap_reduce}, 3'h7);
    xfer(1'b1, `ADDR_OFF_CMD, 32'h0);
    aux_supply_in <= 1'b1;
    wait_irq();
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("aux mode", {q[2:0], load_cap_reduce}, 4'hc);
    @(posedge hclk);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    aux_supply_in <= 1'b0;
    step(3);
    chk("aux to idle", {internal_supply_en, load_cap_reduce}, 2'h3);
    xfer(1'b1, `ADDR_CTRL3, 32'h2);
    osc_amp_ok <= 1'b1;
    step(20);
    chk("reset released", mcu_reset_n, 1'b1);
    r0 = rises;
    step(60);
    chk("clock gated", rises - r0, 0);
    xfer(1'b1, `ADDR_CTRL3, 32'h3);
    step(12);
    r0 = rises;
    step(60);
    chk("clock rate", rises - r0, 10);
    $display("test clock done");
    words = '{13'h0edb, 13'h0fd5, synth_word_a_word};
    for (i = 0; i < 3; i++)
    begin
      xfer(1'b1, `ADDR_CTRL2, {24'h0, words[i][6:0], 1'b0});
      xfer(1'b1, `ADDR_CTRL3, {24'h0, words[i][12:7], 2'b11});
      step(3);
      chk("synth word", synth_word_a, words[i]);
    end
    xfer(1'b1, `ADDR_CTRL1, 32'h10);
    step(3);
    chk("band bit", band_select_bit, 1'b1);
    for (i = 0; i < 8; i++)
    begin
      xfer(1'b1, `ADDR_CTRL6, 32'(i % 4));
      xfer(1'b1, `ADDR_CTRL4, 32'(i / 4));
      period(c);
      period(c);
      chk("bit period", c, 32 * (8 >> (i % 4)) * (i / 4 + 1));
    end
    $display("test timing done");
    for (i = 0; i < 2; i++)
    begin
      xfer(1'b1, `ADDR_CTRL3, i ? 32'h1 : 32'h3);
      step(2);
      chk("supply out", supply_out, i ? 1'b0 : 1'b1);
      xfer(1'b1, `ADDR_CTRL6, 32'h3);
      supply_out_good <= 1'b0;
      step(2);
      chk("reset on drop", mcu_reset_n, 1'b0);
      @(posedge hclk);
      supply_out_good <= 1'b1;
      xfer(1'b0, `ADDR_CTRL6, 32'h0);
      chk("logic reset", q, i ? 32'h3 : 32'h0);
    end
    low_batt_in <= 1'b1;
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("batt held", q[6], 1'b1);
    low_batt_in <= 1'b0;
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("batt cleared", q[6], 1'b0);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("response", hresp, 1'b0);
    $display("test supply done");
    print_verdict();
  end
endmodule : testbench

// >>> dv/xto_ctrl_checker.sv
// Purpose: timing checks on clock, reset and wake outputs
// Assumes: hclk is twice the crystal rate
// Notes: sees top ports only
`timescale 1ns/10ps
module xto_ctrl_checker
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // monitors and wake inputs
  input wire logic osc_amp_ok,
  input wire logic supply_out_good,
  input wire logic aux_supply_in,
  input wire logic power_on_in,
  input wire logic [4:0] button_n,
  // observed outputs
  input wire logic mcu_clk,
  input wire logic mcu_reset_n,
  input wire logic irq,
  input wire logic internal_supply_en,
  input wire logic base_tick
);
  logic idle_in;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======================================================
  // checks
  assign idle_in = !power_on_in && (&button_n) && !aux_supply_in;
  sequence low_then_high;
    !mcu_clk [*3] ##1 mcu_clk;
  endsequence
  // a supply drop may cut a phase short
  clk_high_phase_a: assert property (disable iff (!hresetn || !supply_out_good)
    mcu_clk ##1 low_then_high |-> mcu_clk [*3] ##1 !mcu_clk) else $error("clock high phase");
  clk_low_phase_a: assert property (disable iff (!hresetn || !supply_out_good)
    $fell(mcu_clk) |-> !mcu_clk [*3]) else $error("clock low phase");
  osc_gate_a: assert property (!osc_amp_ok |-> ##2 (!mcu_clk && !mcu_reset_n))
    else $error("clock or reset without oscillator");
  reset_supply_a: assert property (!supply_out_good |=> !mcu_reset_n)
    else $error("reset not low on supply drop");
  base_period_a: assert property (base_tick |-> ##32 base_tick) else $error("base period");
  wake_power_a: assert property ($rose(power_on_in) && !internal_supply_en |-> ##[1:2] irq)
    else $error("no wake by power on");
  wake_button_a: assert property ($fell(&button_n) && !internal_supply_en |-> ##[1:2] irq)
    else $error("no wake by button");
  stay_off_a: assert property (!internal_supply_en && idle_in && $past(idle_in)
    |=> !internal_supply_en) else $error("left off without wake");
  irq_pulse_a: assert property (irq |=> !irq) else $error("irq longer than one cycle");
endmodule : xto_ctrl_checker

bind xto_clock_reset_power_control xto_ctrl_checker u_chk (.hclk, .hresetn, .osc_amp_ok,
  .supply_out_good, .aux_supply_in, .power_on_in, .button_n, .mcu_clk, .mcu_reset_n, .irq,
  .internal_supply_en, .base_tick);
